// ---- src/asom_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module asom_top
	import asom_pkg::*;
#(
	parameter int MODE_DELAY = MODE_DELAY_CYC
) (
	input  wire logic                 CLK,
	input  wire logic                 RST,
	input  wire logic                 OBJ_REQ,
	input  wire logic                 OBJ_WE,
	input  wire logic [OBJ_IDX_W-1:0] OBJ_INDEX,
	input  wire logic [DATA_W-1:0]    OBJ_WDATA,
	output logic                      OBJ_ACK,
	output logic                      OBJ_ERR,
	output logic [DATA_W-1:0]         OBJ_RDATA,
	input  wire logic [MFR_W-1:0]     MFR_STATUS,
	output logic                      STATUS_LIMIT,
	input  wire logic                 EV_QUICK_STOP,
	input  wire logic                 EV_SHUTDOWN,
	input  wire logic                 EV_DISABLE_OP,
	input  wire logic                 EV_HALT,
	input  wire logic                 MOVE_DONE,
	input  wire logic                 RESUME,
	output logic                      PWR_DISABLE,
	output logic [1:0]                RAMP_SEL,
	output logic                      STOP_BUSY,
	output logic                      QS_HOLD,
	output logic                      GOTO_SOD,
	output logic                      STOP_DONE,
	output logic [MODE_W-1:0]         ACTIVE_MODE
);

	initial begin
		if (MODE_DELAY < 1) begin
			$error("asom_top: MODE_DELAY must be at least one cycle.");
		end
	end

	// Option objects.
	// An undefined code is stored as written; the reaction decode maps it to a safe stop when used.
	logic [CODE_W-1:0] quick_stop_reaction_code;
	logic [CODE_W-1:0] shutdown_reaction_code;
	logic [CODE_W-1:0] disable_op_reaction_code;
	logic [CODE_W-1:0] halt_reaction_code;
	logic [MFR_W-1:0]  limit_mask;

	// Object access decode.
	wire logic hit_qs;
	wire logic hit_sd;
	wire logic hit_do;
	wire logic hit_halt;
	wire logic hit_req;
	wire logic hit_act;
	wire logic hit_mask;
	wire logic hit_any;
	wire logic wr_req;
	wire logic mode_refused;
	wire logic [MODE_W-1:0] requested_drive_mode;
	wire logic [MODE_W-1:0] active_drive_mode;
	wire logic limit_flag;
	logic [DATA_W-1:0] next_rdata;
	wire logic next_err;

	assign hit_qs   = OBJ_INDEX == IDX_QUICK_STOP_CODE;
	assign hit_sd   = OBJ_INDEX == IDX_SHUTDOWN_CODE;
	assign hit_do   = OBJ_INDEX == IDX_DISABLE_OP_CODE;
	assign hit_halt = OBJ_INDEX == IDX_HALT_CODE;
	assign hit_req  = OBJ_INDEX == IDX_REQ_MODE;
	assign hit_act  = OBJ_INDEX == IDX_ACTIVE_MODE;
	assign hit_mask = OBJ_INDEX == IDX_LIMIT_MASK;
	assign hit_any  = hit_qs || hit_sd || hit_do || hit_halt || hit_req || hit_act || hit_mask;
	assign wr_req   = OBJ_REQ && OBJ_WE && hit_req;

	// Unknown objects, writes to the display object and unsupported modes all answer with an error.
	assign next_err = !hit_any || (OBJ_WE && hit_act) || mode_refused;

	always_comb begin
		next_rdata = '0;
		if (hit_qs) begin
			next_rdata[CODE_W-1:0] = quick_stop_reaction_code;
		end else if (hit_sd) begin
			next_rdata[CODE_W-1:0] = shutdown_reaction_code;
		end else if (hit_do) begin
			next_rdata[CODE_W-1:0] = disable_op_reaction_code;
		end else if (hit_halt) begin
			next_rdata[CODE_W-1:0] = halt_reaction_code;
		end else if (hit_req) begin
			next_rdata[MODE_W-1:0] = requested_drive_mode;
		end else if (hit_act) begin
			next_rdata[MODE_W-1:0] = active_drive_mode;
		end else if (hit_mask) begin
			next_rdata[MFR_W-1:0] = limit_mask;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			quick_stop_reaction_code <= RST_QUICK_STOP_CODE;
			shutdown_reaction_code   <= RST_SHUTDOWN_CODE;
			disable_op_reaction_code <= RST_DISABLE_OP_CODE;
			halt_reaction_code       <= RST_HALT_CODE;
			limit_mask               <= RST_LIMIT_MASK;
		end else if (OBJ_REQ && OBJ_WE) begin
			if (hit_qs) begin
				quick_stop_reaction_code <= OBJ_WDATA[CODE_W-1:0];
			end
			if (hit_sd) begin
				shutdown_reaction_code <= OBJ_WDATA[CODE_W-1:0];
			end
			if (hit_do) begin
				disable_op_reaction_code <= OBJ_WDATA[CODE_W-1:0];
			end
			if (hit_halt) begin
				halt_reaction_code <= OBJ_WDATA[CODE_W-1:0];
			end
			if (hit_mask) begin
				limit_mask <= OBJ_WDATA[MFR_W-1:0];
			end
		end
	end

	// Read data is zero outside a read answer, so a stale word never looks like a fresh one.
	always_ff @(posedge CLK) begin
		if (RST) begin
			OBJ_ACK   <= 1'b0;
			OBJ_ERR   <= 1'b0;
			OBJ_RDATA <= '0;
		end else begin
			OBJ_ACK   <= OBJ_REQ;
			OBJ_ERR   <= OBJ_REQ && next_err;
			OBJ_RDATA <= (OBJ_REQ && !OBJ_WE) ? next_rdata : '0;
		end
	end

	// The flag is registered in the limit module and again at the pin, two edges after a status change.
	asom_limit #(
		.WIDTH (MFR_W)
	) u_limit (
		.clk        (CLK),
		.rst        (RST),
		.mfr_status (MFR_STATUS),
		.limit_mask (limit_mask),
		.limit_flag (limit_flag)
	);

	// The mode object refuses unsupported codes itself; its refusal only feeds the error answer.
	asom_mode #(
		.DELAY (MODE_DELAY)
	) u_mode (
		.clk       (CLK),
		.rst       (RST),
		.wr        (wr_req),
		.wdata     (OBJ_WDATA[MODE_W-1:0]),
		.refused   (mode_refused),
		.requested (requested_drive_mode),
		.active    (active_drive_mode)
	);

	// Reaction decode: the event and its option code give a ramp and a final state.
	// A code outside the defined set falls back to disabling the outputs, the safest choice.
	asom_ramp_t ev_ramp;
	asom_end_t  ev_end;
	wire logic  any_event;

	// Simultaneous events resolve by priority: quick stop, then shutdown, disable-operation and halt.
	assign any_event = EV_QUICK_STOP || EV_SHUTDOWN || EV_DISABLE_OP || EV_HALT;

	always_comb begin
		ev_ramp = ASOM_RAMP_NONE;
		ev_end  = ASOM_END_NONE;
		if (EV_QUICK_STOP) begin
			unique case (quick_stop_reaction_code)
				CODE_PROFILE: begin
					ev_ramp = ASOM_RAMP_PROFILE;
					ev_end  = ASOM_END_SOD;
				end
				CODE_QUICK: begin
					ev_ramp = ASOM_RAMP_QUICK;
					ev_end  = ASOM_END_SOD;
				end
				CODE_ABRUPT: begin
					ev_ramp = ASOM_RAMP_ABRUPT;
					ev_end  = ASOM_END_SOD;
				end
				CODE_PROF_STAY: begin
					ev_ramp = ASOM_RAMP_PROFILE;
					ev_end  = ASOM_END_QS;
				end
				CODE_QUIC_STAY: begin
					ev_ramp = ASOM_RAMP_QUICK;
					ev_end  = ASOM_END_QS;
				end
				CODE_ABRU_STAY: begin
					ev_ramp = ASOM_RAMP_ABRUPT;
					ev_end  = ASOM_END_QS;
				end
				default: begin
					ev_ramp = ASOM_RAMP_NONE;
				end
			endcase
		end else if (EV_SHUTDOWN) begin
			if (shutdown_reaction_code == CODE_PROFILE) begin
				ev_ramp = ASOM_RAMP_PROFILE;
			end
		end else if (EV_DISABLE_OP) begin
			if (disable_op_reaction_code == CODE_DIS_RAMP) begin
				ev_ramp = ASOM_RAMP_PROFILE;
			end
		end else if (EV_HALT) begin
			unique case (halt_reaction_code)
				CODE_PROFILE: ev_ramp = ASOM_RAMP_PROFILE;
				CODE_QUICK:   ev_ramp = ASOM_RAMP_QUICK;
				CODE_ABRUPT:  ev_ramp = ASOM_RAMP_ABRUPT;
				default:      ev_ramp = ASOM_RAMP_NONE;
			endcase
		end
	end

	// Stop sequencer. The decoded reaction is latched on the event and held until the stop ends,
	// so rewriting an option object mid-stop cannot change a stop already under way.
	asom_state_t state;
	asom_state_t next_state;
	asom_ramp_t  held_ramp;
	asom_end_t   held_end;
	wire logic   finish;

	assign finish = (state == ASOM_RAMP) && MOVE_DONE;

	always_comb begin
		next_state = state;
		unique case (state)
			ASOM_IDLE: begin
				if (any_event) begin
					next_state = (ev_ramp == ASOM_RAMP_NONE) ? ASOM_OFF : ASOM_RAMP;
				end
			end
			// OFF and HOLD are left only by an explicit resume from the drive state machine.
			ASOM_OFF: begin
				if (RESUME) begin
					next_state = ASOM_IDLE;
				end
			end
			ASOM_RAMP: begin
				if (MOVE_DONE) begin
					next_state = (held_end == ASOM_END_QS) ? ASOM_HOLD : ASOM_IDLE;
				end
			end
			ASOM_HOLD: begin
				if (RESUME) begin
					next_state = ASOM_IDLE;
				end
			end
			default: next_state = ASOM_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state     <= ASOM_IDLE;
			held_ramp <= ASOM_RAMP_NONE;
			held_end  <= ASOM_END_NONE;
		end else begin
			state <= next_state;
			if (state == ASOM_IDLE && any_event) begin
				held_ramp <= ev_ramp;
				held_end  <= ev_end;
			end
		end
	end

	// The first ramp cycle takes the freshly decoded reaction and later cycles the held copy,
	// so the ramp choice cannot change while a stop is under way.
	wire logic [1:0] next_ramp_sel;
	wire logic       next_stop_done;

	assign next_ramp_sel  = (next_state != ASOM_RAMP) ? ASOM_RAMP_NONE
		: ((state == ASOM_IDLE) ? ev_ramp : held_ramp);
	assign next_stop_done = finish || (state == ASOM_IDLE && next_state == ASOM_OFF);

	always_ff @(posedge CLK) begin
		if (RST) begin
			PWR_DISABLE  <= 1'b0;
			RAMP_SEL     <= 2'h0;
			STOP_BUSY    <= 1'b0;
			QS_HOLD      <= 1'b0;
			GOTO_SOD     <= 1'b0;
			STOP_DONE    <= 1'b0;
			STATUS_LIMIT <= 1'b0;
			ACTIVE_MODE  <= RST_MODE;
		end else begin
			PWR_DISABLE  <= (next_state == ASOM_OFF);
			RAMP_SEL     <= next_ramp_sel;
			STOP_BUSY    <= (next_state == ASOM_RAMP);
			QS_HOLD      <= (next_state == ASOM_HOLD);
			GOTO_SOD     <= finish && (held_end == ASOM_END_SOD);
			STOP_DONE    <= next_stop_done;
			STATUS_LIMIT <= limit_flag;
			ACTIVE_MODE  <= active_drive_mode;
		end
	end

endmodule
`default_nettype wire

// ---- inc/asom_pkg.sv ----
// What this block does
// - The status word limit bit (bit 11) is set while any manufacturer status bit and its limit mask bit are both set.
// - The limit bit is clear when every manufacturer status bit selected by the limit mask is clear.
// - A quick stop with quick-stop code 0 disables the power outputs at once.
// - Quick-stop code 1 ramps down on the profile deceleration and enters switch-on-disabled only once the move is done.
// - Quick-stop code 2 ramps on the quick-stop deceleration, code 3 stops abruptly, and both then enter switch-on-disabled.
// - Quick-stop codes 5, 6 and 7 stop on the profile ramp, quick-stop ramp or abruptly and then stay in quick stop.
// - Leaving operation enabled for ready to switch on disables the outputs for shutdown code 0 and ramps normally for 1.
// - Leaving operation enabled for switched on disables the outputs for disable code 0 and ramps normally for 16.
// - A halt disables the outputs for code 0, ramps normally for 1, on the quick-stop ramp for 2 and stops abruptly for 3.
// - Requested mode codes 1, 3, 4, 6 and 7 are supported.
// - A write of any other value to the requested mode is refused.
// - A new mode takes effect only after a delay, and the controller learns the mode in force from the display object.
// - The active operating mode is shown in the read-only mode display object.
`default_nettype none
package asom_pkg;

	localparam int OBJ_IDX_W = 16;
	localparam int DATA_W    = 32;
	localparam int CODE_W    = 16;
	localparam int MODE_W    = 8;
	localparam int MFR_W     = 32;

	localparam logic [15:0] IDX_QUICK_STOP_CODE = 16'h605A;
	localparam logic [15:0] IDX_SHUTDOWN_CODE   = 16'h605B;
	localparam logic [15:0] IDX_DISABLE_OP_CODE = 16'h605C;
	localparam logic [15:0] IDX_HALT_CODE       = 16'h605D;
	localparam logic [15:0] IDX_REQ_MODE        = 16'h6060;
	localparam logic [15:0] IDX_ACTIVE_MODE     = 16'h6061;
	localparam logic [15:0] IDX_LIMIT_MASK      = 16'h2180;

	localparam int STATUS_LIMIT_BIT = 11;

	localparam logic [CODE_W-1:0] RST_QUICK_STOP_CODE = 16'h0002;
	localparam logic [CODE_W-1:0] RST_SHUTDOWN_CODE   = 16'h0000;
	localparam logic [CODE_W-1:0] RST_DISABLE_OP_CODE = 16'h0000;
	localparam logic [CODE_W-1:0] RST_HALT_CODE       = 16'h0001;
	localparam logic [MFR_W-1:0]  RST_LIMIT_MASK      = 32'h00000000;
	localparam logic [MODE_W-1:0] RST_MODE            = 8'h00;

	localparam logic [CODE_W-1:0] CODE_DISABLE   = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_PROFILE   = 16'h0001;
	localparam logic [CODE_W-1:0] CODE_QUICK     = 16'h0002;
	localparam logic [CODE_W-1:0] CODE_ABRUPT    = 16'h0003;
	localparam logic [CODE_W-1:0] CODE_PROF_STAY = 16'h0005;
	localparam logic [CODE_W-1:0] CODE_QUIC_STAY = 16'h0006;
	localparam logic [CODE_W-1:0] CODE_ABRU_STAY = 16'h0007;
	localparam logic [CODE_W-1:0] CODE_DIS_RAMP  = 16'h0010;

	localparam logic [MODE_W-1:0] MODE_PROF_POS  = 8'h01;
	localparam logic [MODE_W-1:0] MODE_PROF_VEL  = 8'h03;
	localparam logic [MODE_W-1:0] MODE_PROF_TRQ  = 8'h04;
	localparam logic [MODE_W-1:0] MODE_HOMING    = 8'h06;
	localparam logic [MODE_W-1:0] MODE_INTERP    = 8'h07;

	localparam real MODE_DELAY_NS   = 1000.0;
	localparam real CLK_PERIOD_NS   = 4.0;
	localparam int  MODE_DELAY_CYC  = int'(MODE_DELAY_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		ASOM_RAMP_NONE    = 2'h0,
		ASOM_RAMP_PROFILE = 2'h1,
		ASOM_RAMP_QUICK   = 2'h2,
		ASOM_RAMP_ABRUPT  = 2'h3
	} asom_ramp_t;

	typedef enum logic [1:0] {
		ASOM_END_NONE = 2'h0,
		ASOM_END_SOD  = 2'h1,
		ASOM_END_QS   = 2'h2
	} asom_end_t;

	typedef enum logic [3:0] {
		ASOM_IDLE = 4'h1,
		ASOM_OFF  = 4'h2,
		ASOM_RAMP = 4'h4,
		ASOM_HOLD = 4'h8
	} asom_state_t;

endpackage
`default_nettype wire

// ---- src/asom_limit.sv ----
`timescale 1ns/1ps
`default_nettype none
module asom_limit
	import asom_pkg::*;
#(
	parameter int WIDTH = MFR_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] mfr_status,
	input  wire logic [WIDTH-1:0] limit_mask,
	output logic                  limit_flag
);

	initial begin
		if (WIDTH < 1) begin
			$error("asom_limit: WIDTH must be at least 1.");
		end
	end

	wire logic [WIDTH-1:0] selected;
	wire logic             next_limit_flag;

	assign selected        = mfr_status & limit_mask;
	assign next_limit_flag = |selected;

	always_ff @(posedge clk) begin
		if (rst) begin
			limit_flag <= 1'b0;
		end else begin
			limit_flag <= next_limit_flag;
		end
	end

endmodule
`default_nettype wire

// ---- src/asom_mode.sv ----
`timescale 1ns/1ps
`default_nettype none
module asom_mode
	import asom_pkg::*;
#(
	parameter int DELAY = MODE_DELAY_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              wr,
	input  wire logic [MODE_W-1:0] wdata,
	output logic                   refused,
	output logic [MODE_W-1:0]      requested,
	output logic [MODE_W-1:0]      active
);

	localparam int CNT_W = $clog2(DELAY + 1);

	initial begin
		if (DELAY < 1) begin
			$error("asom_mode: DELAY must be at least one cycle.");
		end
	end

	function automatic logic mode_ok(input logic [MODE_W-1:0] m);
		mode_ok = (m == MODE_PROF_POS) || (m == MODE_PROF_VEL) || (m == MODE_PROF_TRQ)
			|| (m == MODE_HOMING) || (m == MODE_INTERP);
	endfunction

	logic [CNT_W-1:0]  wait_cnt;
	logic              pending;
	wire logic         accept;

	assign accept  = wr && mode_ok(wdata);
	assign refused = wr && !mode_ok(wdata);

	// A later accepted write restarts the wait, so only the last accepted mode becomes active.
	always_ff @(posedge clk) begin
		if (rst) begin
			requested <= RST_MODE;
			active    <= RST_MODE;
			pending   <= 1'b0;
			wait_cnt  <= '0;
		end else if (accept) begin
			requested <= wdata;
			pending   <= 1'b1;
			wait_cnt  <= CNT_W'(DELAY - 1);
		end else if (pending && wait_cnt == '0) begin
			active  <= requested;
			pending <= 1'b0;
		end else if (pending) begin
			wait_cnt <= wait_cnt - CNT_W'(1);
		end
	end

endmodule
`default_nettype wire

// ---- bench/asom_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module asom_monitor
	import asom_pkg::*;
#(
	parameter int MODE_DELAY = MODE_DELAY_CYC
) (
	input wire logic                 CLK,
	input wire logic                 RST,
	input wire logic                 OBJ_REQ,
	input wire logic                 OBJ_WE,
	input wire logic [OBJ_IDX_W-1:0] OBJ_INDEX,
	input wire logic [DATA_W-1:0]    OBJ_WDATA,
	input wire logic                 OBJ_ACK,
	input wire logic                 OBJ_ERR,
	input wire logic [MFR_W-1:0]     MFR_STATUS,
	input wire logic                 STATUS_LIMIT,
	input wire logic                 MOVE_DONE,
	input wire logic                 PWR_DISABLE,
	input wire logic [1:0]           RAMP_SEL,
	input wire logic                 STOP_BUSY,
	input wire logic                 QS_HOLD,
	input wire logic                 GOTO_SOD,
	input wire logic                 STOP_DONE,
	input wire logic [MODE_W-1:0]    ACTIVE_MODE
);
	logic [MFR_W-1:0] mask;
	logic             hit1;
	logic             hit2;
	wire logic        wr_mode = OBJ_REQ && OBJ_WE && OBJ_INDEX == IDX_REQ_MODE;
	wire logic        good    = OBJ_WDATA[7:0] inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h07};

	// The mask is mirrored here because only the port side is visible; mask writes are never refused.
	always_ff @(posedge CLK) begin
		if (RST) begin
			mask <= RST_LIMIT_MASK;
			hit1 <= 1'h0;
			hit2 <= 1'h0;
		end else begin
			if (OBJ_REQ && OBJ_WE && OBJ_INDEX == IDX_LIMIT_MASK) begin
				mask <= OBJ_WDATA;
			end
			hit1 <= |(MFR_STATUS & mask);
			hit2 <= hit1;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	limit_set_a: assert property (hit2 |-> STATUS_LIMIT)
		else $error("limit flag missing");
	limit_clear_a: assert property (!hit2 |-> !STATUS_LIMIT)
		else $error("limit flag stuck");
	mode_accept_a: assert property (wr_mode && good |=> OBJ_ACK && !OBJ_ERR)
		else $error("good mode refused");
	mode_refuse_a: assert property (wr_mode && !good |=> OBJ_ACK && OBJ_ERR)
		else $error("bad mode taken");
	mode_delay_a: assert property (wr_mode && good |=> $stable(ACTIVE_MODE)[*4])
		else $error("mode applied too soon");
	power_off_a: assert property ($rose(PWR_DISABLE) |-> STOP_DONE && !GOTO_SOD && RAMP_SEL == 2'h0)
		else $error("bad power off");
	ramp_hold_a: assert property (STOP_BUSY && !MOVE_DONE |=> STOP_BUSY && $stable(RAMP_SEL))
		else $error("ramp not held");
	stop_end_a: assert property (STOP_BUSY && MOVE_DONE |=> STOP_DONE && !STOP_BUSY && RAMP_SEL == 2'h0
		##1 !STOP_DONE && !GOTO_SOD)
		else $error("bad stop end");
	qs_stay_a: assert property ($rose(QS_HOLD) |-> $fell(STOP_BUSY) && !GOTO_SOD)
		else $error("bad quick stop hold");

	cover property (GOTO_SOD);
	cover property ($rose(QS_HOLD));
	cover property (wr_mode && !good);
endmodule
`default_nettype wire

// ---- bench/asom_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module asom_master
	import asom_pkg::*;
(
	input  wire logic        clk,
	output logic             req,
	output logic             we,
	output logic [15:0]      idx,
	output logic [31:0]      wdata,
	input  wire logic        ack,
	input  wire logic        err,
	input  wire logic [31:0] rdata
);
	initial begin
		req = 1'h0;
		we = 1'h0;
		idx = 16'hFFFF;
		wdata = 32'h0;
	end

	// Called just after an edge; the caller hands in only defined option codes.
	task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
		output logic e, output logic [31:0] r);
		int n;
		n = 0;
		req = 1'h1;
		we = w;
		idx = i;
		wdata = d;
		@(posedge clk);
		#1;
		// The request is a one-cycle pulse. Released lines carry the inverse so a stale word never passes.
		req = 1'h0;
		we = ~w;
		idx = ~i;
		wdata = ~d;
		while (ack !== 1'h1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (ack !== 1'h1) begin
			tb.num_errors++;
			tb.stop_test();
		end
		e = err;
		r = rdata;
		// One idle edge keeps the next request from being raised in this same time step.
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
	import asom_pkg::*;
;
	localparam int MD = 4;
	logic        clk, rst, req, we, ack, err, limit, move_done, resume, pwr, busy, hold, sod, done;
	logic [15:0] idx;
	logic [31:0] wdata, rdata, mfr;
	logic [3:0]  ev;
	logic [1:0]  ramp;
	logic [7:0]  amode;
	int          num_errors = 0, num_checks = 0;

	asom_top #(.MODE_DELAY(MD)) dut (.CLK(clk), .RST(rst), .OBJ_REQ(req), .OBJ_WE(we), .OBJ_INDEX(idx),
		.OBJ_WDATA(wdata), .OBJ_ACK(ack), .OBJ_ERR(err), .OBJ_RDATA(rdata), .MFR_STATUS(mfr),
		.STATUS_LIMIT(limit), .EV_QUICK_STOP(ev[0]), .EV_SHUTDOWN(ev[1]), .EV_DISABLE_OP(ev[2]),
		.EV_HALT(ev[3]), .MOVE_DONE(move_done), .RESUME(resume), .PWR_DISABLE(pwr), .RAMP_SEL(ramp),
		.STOP_BUSY(busy), .QS_HOLD(hold), .GOTO_SOD(sod), .STOP_DONE(done), .ACTIVE_MODE(amode));
	asom_master m (.clk(clk), .req(req), .we(we), .idx(idx), .wdata(wdata), .ack(ack), .err(err), .rdata(rdata));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task rd(input logic [15:0] i, input logic [31:0] v, input logic e);
		logic        er;
		logic [31:0] d;
		m.access(1'h0, i, 32'h0, er, d);
		chk(er, e);
		if (!e) chk(d, v);
	endtask

	task wr(input logic [15:0] i, input logic [31:0] v, input logic e);
		logic        er;
		logic [31:0] d;
		m.access(1'h1, i, v, er, d);
		chk(er, e);
	endtask

	task t_regs;
		logic [15:0] ri [7];
		logic [31:0] rv [7];
		ri = '{IDX_QUICK_STOP_CODE, IDX_SHUTDOWN_CODE, IDX_DISABLE_OP_CODE, IDX_HALT_CODE,
			IDX_LIMIT_MASK, IDX_REQ_MODE, IDX_ACTIVE_MODE};
		rv = '{32'h2, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
		for (int k = 0; k < 7; k++) rd(ri[k], rv[k], 1'h0);
		rd(16'h1234, 32'h0, 1'h1);
		wr(IDX_ACTIVE_MODE, 32'h1, 1'h1);
		wr(IDX_HALT_CODE, 32'h3, 1'h0);
		rd(IDX_HALT_CODE, 32'h3, 1'h0);
		$display("test regs done");
	endtask

	task t_limit;
		wr(IDX_LIMIT_MASK, 32'h00000500, 1'h0);
		mfr = 32'h00000400;
		tick(2);
		chk(limit, 1'h1);
		mfr = 32'hFFFFFAFF;
		tick(2);
		chk(limit, 1'h0);
		mfr = 32'h00000100;
		tick(2);
		chk(limit, 1'h1);
		// The mask reaches the flag one cycle later than a status change does.
		wr(IDX_LIMIT_MASK, 32'h0, 1'h0);
		chk(limit, 1'h1);
		tick(1);
		chk(limit, 1'h0);
		mfr = 32'h0;
		$display("test limit done");
	endtask

	task t_mode;
		logic [7:0] ok [5];
		logic [7:0] bad [5];
		logic [7:0] p;
		ok = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07};
		bad = '{8'h00, 8'h02, 8'h05, 8'h08, 8'hFF};
		p = 8'h00;
		for (int k = 0; k < 5; k++) begin
			// The mode reaches the pins MD + 1 edges after it is taken; the bus task spends one.
			wr(IDX_REQ_MODE, {24'h0, ok[k]}, 1'h0);
			tick(MD - 1);
			chk(amode, p);
			tick(1);
			chk(amode, ok[k]);
			rd(IDX_ACTIVE_MODE, {24'h0, ok[k]}, 1'h0);
			p = ok[k];
		end
		for (int k = 0; k < 5; k++) wr(IDX_REQ_MODE, {24'h0, bad[k]}, 1'h1);
		rd(IDX_REQ_MODE, 32'h7, 1'h0);
		wr(IDX_REQ_MODE, 32'h1, 1'h0);
		wr(IDX_REQ_MODE, 32'h3, 1'h0);
		tick(MD - 1);
		chk(amode, 8'h07);
		tick(1);
		chk(amode, 8'h03);
		$display("test mode done");
	endtask

	task sc(input logic [3:0] e, input logic [15:0] i, input logic [15:0] c, input logic [1:0] r,
		input logic [1:0] k);
		wr(i, {16'h0, c}, 1'h0);
		ev = e;
		tick(1);
		ev = 4'h0;
		if (r == 2'h0) begin
			chk({pwr, done, ramp}, 4'hC);
			tick(1);
			chk({pwr, done}, 2'h2);
			resume = 1'h1;
			tick(1);
			resume = 1'h0;
			chk(pwr, 1'h0);
		end else begin
			chk({busy, ramp, pwr}, {1'h1, r, 1'h0});
			// A new code and a second event mid-stop must not disturb the running reaction.
			ev = 4'h1;
			wr(i, 32'h0, 1'h0);
			ev = 4'h0;
			tick(2);
			chk({busy, ramp, pwr}, {1'h1, r, 1'h0});
			move_done = 1'h1;
			tick(1);
			move_done = 1'h0;
			chk({busy, ramp, done, sod, hold}, {4'h1, k == 2'h1, k == 2'h2});
			tick(1);
			chk({done, sod, hold}, {2'h0, k == 2'h2});
			resume = 1'h1;
			tick(1);
			resume = 1'h0;
			chk(hold, 1'h0);
		end
	endtask

	task t_stop;
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h0, 2'h0, 2'h0);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h1, 2'h1, 2'h1);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h2, 2'h2, 2'h1);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h3, 2'h3, 2'h1);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h5, 2'h1, 2'h2);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h6, 2'h2, 2'h2);
		sc(4'h1, IDX_QUICK_STOP_CODE, 16'h7, 2'h3, 2'h2);
		sc(4'h2, IDX_SHUTDOWN_CODE, 16'h0, 2'h0, 2'h0);
		sc(4'h2, IDX_SHUTDOWN_CODE, 16'h1, 2'h1, 2'h0);
		sc(4'h4, IDX_DISABLE_OP_CODE, 16'h0, 2'h0, 2'h0);
		sc(4'h4, IDX_DISABLE_OP_CODE, 16'h10, 2'h1, 2'h0);
		for (int c = 0; c < 4; c++) sc(4'h8, IDX_HALT_CODE, c[15:0], c[1:0], 2'h0);
		$display("test stop done");
	endtask

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	initial begin
		rst = 1'h1;
		mfr = 32'h0;
		ev = 4'h0;
		move_done = 1'h0;
		resume = 1'h0;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'h0;
		t_regs();
		t_limit();
		t_mode();
		t_stop();
		stop_test();
	end
endmodule

bind asom_top asom_monitor #(.MODE_DELAY(MODE_DELAY)) u_mon (.CLK(CLK), .RST(RST), .OBJ_REQ(OBJ_REQ),
	.OBJ_WE(OBJ_WE), .OBJ_INDEX(OBJ_INDEX), .OBJ_WDATA(OBJ_WDATA), .OBJ_ACK(OBJ_ACK), .OBJ_ERR(OBJ_ERR),
	.MFR_STATUS(MFR_STATUS), .STATUS_LIMIT(STATUS_LIMIT), .MOVE_DONE(MOVE_DONE), .PWR_DISABLE(PWR_DISABLE),
	.RAMP_SEL(RAMP_SEL), .STOP_BUSY(STOP_BUSY), .QS_HOLD(QS_HOLD), .GOTO_SOD(GOTO_SOD),
	.STOP_DONE(STOP_DONE), .ACTIVE_MODE(ACTIVE_MODE));
`default_nettype wire
